// ==== hdl/mmu_pkg.sv ====
// Purpose: Shared constants and carrier types for the translation fault checker.
// Assumes: Register offsets are byte addresses on a 32-bit APB.
// Notes:   Fault codes are four bits and domains are four bits.
`default_nettype none
package mmu_pkg;
	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_DOMAIN  = 8'h04;
	localparam logic [7:0] OFS_LOCK    = 8'h08;
	localparam logic [7:0] OFS_DFSR    = 8'h0C;
	localparam logic [7:0] OFS_IFSR    = 8'h10;
	localparam logic [7:0] OFS_FADDR   = 8'h14;
	localparam logic [7:0] OFS_INV_ALL = 8'h18;
	localparam logic [7:0] OFS_INV_VA  = 8'h1C;
	localparam int CTRL_XLAT    = 0;
	localparam int CTRL_S       = 1;
	localparam int CTRL_R       = 2;
	localparam int LOCK_EN      = 0;
	localparam int LOCK_VIC_LSB = 4;
	// --------------------------------------------------------------
	// Descriptor layout and encodings
	// --------------------------------------------------------------
	localparam int L1_DOM_LSB     = 5;
	localparam int L1_PERM_LSB    = 10;
	localparam int L2_PERM_LSB    = 4;
	localparam int LARGE_SUB_LSB  = 14;
	localparam int SMALL_SUB_LSB  = 10;
	localparam logic [1:0] L1_FAULT   = 2'h0;
	localparam logic [1:0] L1_SECTION = 2'h2;
	localparam logic [1:0] L2_FAULT   = 2'h0;
	localparam logic [1:0] L2_LARGE   = 2'h1;
	localparam logic [1:0] L2_SMALL   = 2'h2;
	localparam logic [4:0] GRAN_SECTION   = 5'h14;
	localparam logic [4:0] GRAN_LARGE     = 5'h10;
	localparam logic [4:0] GRAN_LARGE_SUB = 5'h0E;
	localparam logic [4:0] GRAN_SMALL     = 5'h0C;
	localparam logic [4:0] GRAN_SMALL_SUB = 5'h0A;
	localparam logic [4:0] GRAN_TINY      = 5'h0A;
	localparam logic [1:0] DOM_NOACC  = 2'h0;
	localparam logic [1:0] DOM_CLIENT = 2'h1;
	localparam logic [1:0] DOM_RSVD   = 2'h2;
	localparam logic [1:0] PERM_NONE  = 2'h0;
	localparam logic [1:0] PERM_PRIV  = 2'h1;
	localparam logic [1:0] PERM_UREAD = 2'h2;
	// --------------------------------------------------------------
	// Fault status codes
	// --------------------------------------------------------------
	localparam logic [3:0] FS_EXT_L1     = 4'hC;
	localparam logic [3:0] FS_EXT_L2     = 4'hE;
	localparam logic [3:0] FS_TRANS_SEC  = 4'h5;
	localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
	localparam logic [3:0] FS_DOM_SEC    = 4'h9;
	localparam logic [3:0] FS_DOM_PAGE   = 4'hB;
	localparam logic [3:0] FS_PERM_SEC   = 4'hD;
	localparam logic [3:0] FS_PERM_PAGE  = 4'hF;
	localparam logic [3:0] FS_EXT_SEC    = 4'h8;
	localparam logic [3:0] FS_EXT_PAGE   = 4'hA;
	localparam logic [1:0] FLAT_FETCHES  = 2'h2;
	// --------------------------------------------------------------
	// Types
	// --------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_BUS     = 2'b01,
		ST_SWAP_RD = 2'b10,
		ST_SWAP_WR = 2'b11
	} bus_state_t;
	typedef struct packed {
		logic [31:0] va;
		logic        is_instr;
		logic        is_write;
		logic        is_priv;
		logic        is_swap;
		logic        noncached;
		logic        bufferable;
	} acc_req_t;
	typedef struct packed {
		logic [31:0] l1;
		logic [31:0] l2;
		logic        abort_l1;
		logic        abort_l2;
	} walk_t;
	typedef struct packed {
		logic       valid;
		logic       abort;
		logic [3:0] status;
		logic [3:0] domain;
		logic       is_instr;
		logic       bus_start;
		logic       bus_buffered;
		logic       tlb_hit;
	} rsp_t;
	typedef struct packed {
		logic        valid;
		logic [31:0] tag;
		logic [31:0] mask;
		logic [3:0]  domain;
		logic [1:0]  perm;
		logic        is_page;
	} tlb_ent_t;
endpackage
`default_nettype wire

// ==== hdl/mmu_fault_check.sv ====
// Purpose: Fault checking and translation cache of the memory management unit.
// Assumes: Walk descriptors arrive with the request; APB answers with no wait.
// Notes:   Physical address output and cache behaviour are outside this block.
// Contract
// - Level one type 00 gives translation fault.
// - Domain field selects one of sixteen entries.
// - Domain checked when level one descriptor returns; pages check it after level two abort and fault.
// - No access or reserved domain faults.
// - Client domain goes on to permission check.
// - Section permission from field, S and R.
// - Page uses one of four quarter fields.
// - Small page quarters are 1 KB each.
// - Large page quarters are 16 KB each.
// - Subpage refusal gives page permission fault.
// - Tiny page uses level one permission bits.
// - External abort only on eligible accesses.
// - Swap write issued even after read abort.
// - Bufferable swap behaves as nonbufferable swap.
// - Two fetches stay flat after enable change.
// - Disable keeps translation cache contents intact.
// - Unified cache with eight locked entries.
// - Lockdown setting picks part at write.
// - Locked entry leaves only by overwrite, invalidate.
// - Differing subpages stored as separate entries.
// - Manager domain skips permission check.
// - Abort records status and domain per type.
`timescale 1ns/1ns
`default_nettype none
module mmu_fault_check #(
	parameter int LOCK_ENTRIES = 8,
	parameter int SET_ENTRIES  = 8
) (
	input  wire logic             clk_sys,       // System clock, 20 MHz.
	input  wire logic             nrst,          // Asynchronous reset, active low.
	input  wire logic             psel,          // APB select.
	input  wire logic             penable,       // APB enable.
	input  wire logic             pwrite,        // APB direction.
	input  wire logic [31:0]      paddr,         // APB byte address.
	input  wire logic [31:0]      pwdata,        // APB write data.
	output logic      [31:0]      prdata,        // APB read data.
	output logic                  pready,        // APB ready.
	output logic                  pslverr,       // APB error on unmapped address.
	input  wire logic             req_valid,     // Core access request.
	input  wire mmu_pkg::acc_req_t req,          // Access attributes.
	input  wire mmu_pkg::walk_t   walk,          // Table walk result for a miss.
	output logic                  req_ready,     // Request taken when high.
	output mmu_pkg::rsp_t         rsp,           // Check result, one-cycle valid.
	input  wire logic             bus_done,      // Bus phase complete.
	input  wire logic             bus_err,       // Bus phase error.
	output logic                  swap_write_go, // Start write phase of a swap.
	output logic                  core_ext_abort,// External abort to the core.
	output logic                  xlat_on        // Translation enable setting.
);
	localparam int LW = $clog2(LOCK_ENTRIES);
	localparam int SW = $clog2(SET_ENTRIES);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [2:0]          ctrl_reg;
	logic [31:0]         dacr_reg;
	logic                lock_en_reg;
	logic [LW-1:0]       lock_vic_reg;
	logic [7:0]          dfsr_reg;
	logic [7:0]          ifsr_reg;
	logic [31:0]         far_reg;
	logic [SW-1:0]       set_ptr_reg;
	logic [1:0]          flat_cnt_reg;
	logic                old_xlat_reg;
	logic                ext_ok_reg;
	logic                hold_page_reg;
	logic                hold_instr_reg;
	logic [3:0]          hold_dom_reg;
	logic [31:0]         hold_va_reg;
	mmu_pkg::bus_state_t state_reg;
	mmu_pkg::tlb_ent_t   lock_tlb [LOCK_ENTRIES];
	mmu_pkg::tlb_ent_t   set_tlb  [SET_ENTRIES];
	logic                acc, use_xlat, hit, is_sec, walk_ok, fault, differ;
	logic [3:0]          dom, dom_out, status;
	logic [1:0]          dval, perm, sub, sub_perm;
	logic [4:0]          gran;
	logic [31:0]         mask;
	mmu_pkg::tlb_ent_t   hent, new_ent;
	logic                apb_wr, apb_setup, mapped, inv_all, inv_va, tlb_wr;

	// Permission decision for a two-bit field, as for a section.
	function automatic logic perm_ok(input logic [1:0] p, input logic s, input logic r,
		input logic priv, input logic wr);
		case (p)
			mmu_pkg::PERM_NONE:  perm_ok = (s ^ r) & ~wr;
			mmu_pkg::PERM_PRIV:  perm_ok = priv;
			mmu_pkg::PERM_UREAD: perm_ok = priv | ~wr;
			default:             perm_ok = 1'b1;
		endcase
	endfunction

	// --------------------------------------------------------------
	// APB slave
	// --------------------------------------------------------------
	// Zero-wait slave; misaligned or unknown addresses answer with an error.
	assign pready    = 1'b1;
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pwrite & mapped;
	assign mapped    = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0);
	assign pslverr   = psel & penable & ~mapped;
	assign inv_all   = apb_wr && (paddr[7:0] == mmu_pkg::OFS_INV_ALL);
	assign inv_va    = apb_wr && (paddr[7:0] == mmu_pkg::OFS_INV_VA);
	assign xlat_on   = ctrl_reg[mmu_pkg::CTRL_XLAT];

	// Read data is captured in the setup cycle.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (apb_setup) begin
			case (mapped ? paddr[7:0] : mmu_pkg::OFS_INV_ALL)
				mmu_pkg::OFS_CTRL:   prdata <= {29'h0, ctrl_reg};
				mmu_pkg::OFS_DOMAIN: prdata <= dacr_reg;
				mmu_pkg::OFS_LOCK:   prdata <= (32'(lock_vic_reg) << mmu_pkg::LOCK_VIC_LSB) | 32'(lock_en_reg);
				mmu_pkg::OFS_DFSR:   prdata <= {24'h0, dfsr_reg};
				mmu_pkg::OFS_IFSR:   prdata <= {24'h0, ifsr_reg};
				mmu_pkg::OFS_FADDR:  prdata <= far_reg;
				default:             prdata <= 32'h0;
			endcase
		end
	end

	// Control, domain and lockdown settings.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg     <= 3'h0;
			dacr_reg     <= 32'h0;
			lock_en_reg  <= 1'b0;
			lock_vic_reg <= '0;
		end else if (apb_wr) begin
			if (paddr[7:0] == mmu_pkg::OFS_CTRL)
				ctrl_reg <= pwdata[2:0];
			if (paddr[7:0] == mmu_pkg::OFS_DOMAIN)
				dacr_reg <= pwdata;
			if (paddr[7:0] == mmu_pkg::OFS_LOCK) begin
				lock_en_reg  <= pwdata[mmu_pkg::LOCK_EN];
				lock_vic_reg <= pwdata[mmu_pkg::LOCK_VIC_LSB +: LW];
			end
		end
	end

	// Fetches already in flight keep the old mapping for two instructions.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			flat_cnt_reg <= 2'h0;
			old_xlat_reg <= 1'b0;
		end else if (apb_wr && paddr[7:0] == mmu_pkg::OFS_CTRL &&
			pwdata[mmu_pkg::CTRL_XLAT] != ctrl_reg[mmu_pkg::CTRL_XLAT]) begin
			flat_cnt_reg <= mmu_pkg::FLAT_FETCHES;
			old_xlat_reg <= ctrl_reg[mmu_pkg::CTRL_XLAT];
		end else if (acc && req.is_instr && flat_cnt_reg != 2'h0) begin
			flat_cnt_reg <= flat_cnt_reg - 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Translation cache lookup
	// --------------------------------------------------------------
	// Locked entries are searched last so they win over the other part.
	always_comb begin
		hit  = 1'b0;
		hent = '0;
		for (int i = 0; i < SET_ENTRIES; i++) begin
			if (set_tlb[i].valid && ((req.va & set_tlb[i].mask) == set_tlb[i].tag)) begin
				hit  = 1'b1;
				hent = set_tlb[i];
			end
		end
		for (int i = 0; i < LOCK_ENTRIES; i++) begin
			if (lock_tlb[i].valid && ((req.va & lock_tlb[i].mask) == lock_tlb[i].tag)) begin
				hit  = 1'b1;
				hent = lock_tlb[i];
			end
		end
	end

	// --------------------------------------------------------------
	// Fault check
	// --------------------------------------------------------------
	assign acc       = req_valid && state_reg == mmu_pkg::ST_IDLE;
	assign req_ready = state_reg == mmu_pkg::ST_IDLE;
	assign use_xlat  = (req.is_instr && flat_cnt_reg != 2'h0) ? old_xlat_reg : ctrl_reg[mmu_pkg::CTRL_XLAT];

	// Decodes descriptors or a cached entry into one prioritised fault.
	always_comb begin
		is_sec   = hit ? ~hent.is_page : (walk.l1[1:0] == mmu_pkg::L1_SECTION);
		dom      = hit ? hent.domain : walk.l1[mmu_pkg::L1_DOM_LSB +: 4];
		sub      = (walk.l2[1:0] == mmu_pkg::L2_LARGE) ? req.va[mmu_pkg::LARGE_SUB_LSB +: 2]
			: req.va[mmu_pkg::SMALL_SUB_LSB +: 2];
		sub_perm = walk.l2[(mmu_pkg::L2_PERM_LSB + 2 * int'(sub)) +: 2];
		differ   = walk.l2[mmu_pkg::L2_PERM_LSB +: 8] != {4{walk.l2[mmu_pkg::L2_PERM_LSB +: 2]}};
		gran     = mmu_pkg::GRAN_SECTION;
		perm     = walk.l1[mmu_pkg::L1_PERM_LSB +: 2];
		if (!is_sec) begin
			case (walk.l2[1:0])
				mmu_pkg::L2_LARGE: begin
					gran = differ ? mmu_pkg::GRAN_LARGE_SUB : mmu_pkg::GRAN_LARGE;
					perm = sub_perm;
				end
				mmu_pkg::L2_SMALL: begin
					gran = differ ? mmu_pkg::GRAN_SMALL_SUB : mmu_pkg::GRAN_SMALL;
					perm = sub_perm;
				end
				default: gran = mmu_pkg::GRAN_TINY;
			endcase
		end
		if (hit)
			perm = hent.perm;
		dval    = dacr_reg[{dom, 1'b0} +: 2];
		fault   = 1'b1;
		walk_ok = 1'b0;
		dom_out = dom;
		status  = 4'h0;
		if (!hit && walk.abort_l1) begin
			status  = mmu_pkg::FS_EXT_L1;
			dom_out = 4'h0;
		end else if (!hit && walk.l1[1:0] == mmu_pkg::L1_FAULT) begin
			status  = mmu_pkg::FS_TRANS_SEC;
			dom_out = 4'h0;
		end else if (!hit && !is_sec && walk.abort_l2) begin
			status = mmu_pkg::FS_EXT_L2;
		end else if (!hit && !is_sec && walk.l2[1:0] == mmu_pkg::L2_FAULT) begin
			status = mmu_pkg::FS_TRANS_PAGE;
		end else begin
			walk_ok = ~hit;
			if (dval == mmu_pkg::DOM_NOACC || dval == mmu_pkg::DOM_RSVD)
				status = is_sec ? mmu_pkg::FS_DOM_SEC : mmu_pkg::FS_DOM_PAGE;
			else if (dval == mmu_pkg::DOM_CLIENT && !perm_ok(perm, ctrl_reg[mmu_pkg::CTRL_S],
				ctrl_reg[mmu_pkg::CTRL_R], req.is_priv, req.is_write))
				status = is_sec ? mmu_pkg::FS_PERM_SEC : mmu_pkg::FS_PERM_PAGE;
			else
				fault = 1'b0;
		end
		mask    = ~((32'h1 << gran) - 32'h1);
		new_ent = '{valid: 1'b1, tag: req.va & mask, mask: mask, domain: dom, perm: perm, is_page: ~is_sec};
	end

	assign tlb_wr = acc && use_xlat && walk_ok;

	// Cache store; disabling translation leaves entries untouched.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < LOCK_ENTRIES; i++)
				lock_tlb[i] <= '0;
			for (int i = 0; i < SET_ENTRIES; i++)
				set_tlb[i] <= '0;
			set_ptr_reg <= '0;
		end else begin
			for (int i = 0; i < LOCK_ENTRIES; i++)
				if (inv_va && (pwdata & lock_tlb[i].mask) == lock_tlb[i].tag)
					lock_tlb[i].valid <= 1'b0;
			for (int i = 0; i < SET_ENTRIES; i++)
				if (inv_all || (inv_va && (pwdata & set_tlb[i].mask) == set_tlb[i].tag))
					set_tlb[i].valid <= 1'b0;
			if (tlb_wr && lock_en_reg) begin
				lock_tlb[lock_vic_reg] <= new_ent;
			end else if (tlb_wr) begin
				set_tlb[set_ptr_reg] <= new_ent;
				set_ptr_reg <= (set_ptr_reg == SW'(SET_ENTRIES - 1)) ? '0 : set_ptr_reg + 1'b1;
			end
		end
	end

	// --------------------------------------------------------------
	// Response and bus sequencing
	// --------------------------------------------------------------
	// A faulting access is answered at once and never reaches the bus.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rsp            <= '0;
			state_reg      <= mmu_pkg::ST_IDLE;
			ext_ok_reg     <= 1'b0;
			swap_write_go  <= 1'b0;
			core_ext_abort <= 1'b0;
			hold_page_reg  <= 1'b0;
			hold_instr_reg <= 1'b0;
			hold_dom_reg   <= 4'h0;
			hold_va_reg    <= 32'h0;
		end else begin
			rsp            <= '0;
			swap_write_go  <= 1'b0;
			core_ext_abort <= 1'b0;
			case (state_reg)
				mmu_pkg::ST_IDLE: begin
					if (acc) begin
						rsp.valid    <= 1'b1;
						rsp.is_instr <= req.is_instr;
						rsp.tlb_hit  <= use_xlat & hit;
						rsp.domain   <= use_xlat ? dom_out : 4'h0;
						hold_page_reg  <= use_xlat & ~is_sec;
						hold_instr_reg <= req.is_instr;
						hold_dom_reg   <= use_xlat ? dom : 4'h0;
						hold_va_reg    <= req.va;
						if (use_xlat && fault) begin
							rsp.abort  <= 1'b1;
							rsp.status <= status;
						end else begin
							rsp.bus_start    <= 1'b1;
							rsp.bus_buffered <= req.bufferable & ~req.is_swap;
							ext_ok_reg <= req.is_swap ? req.noncached :
								(req.noncached & ~req.is_write) | (req.is_write & ~req.bufferable);
							state_reg  <= req.is_swap ? mmu_pkg::ST_SWAP_RD : mmu_pkg::ST_BUS;
						end
					end
				end
				mmu_pkg::ST_SWAP_RD: begin
					if (bus_done) begin
						swap_write_go  <= 1'b1;
						core_ext_abort <= bus_err & ext_ok_reg;
						state_reg      <= mmu_pkg::ST_SWAP_WR;
					end
				end
				default: begin
					if (bus_done) begin
						core_ext_abort <= bus_err & ext_ok_reg;
						state_reg      <= mmu_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Fault status and address capture, split by access type.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			dfsr_reg <= 8'h0;
			ifsr_reg <= 8'h0;
			far_reg  <= 32'h0;
		end else if (rsp.valid && rsp.abort) begin
			if (rsp.is_instr) begin
				ifsr_reg <= {rsp.domain, rsp.status};
			end else begin
				dfsr_reg <= {rsp.domain, rsp.status};
				far_reg  <= hold_va_reg;
			end
		end else if (core_ext_abort) begin
			if (hold_instr_reg) begin
				ifsr_reg <= {hold_dom_reg, hold_page_reg ? mmu_pkg::FS_EXT_PAGE : mmu_pkg::FS_EXT_SEC};
			end else begin
				dfsr_reg <= {hold_dom_reg, hold_page_reg ? mmu_pkg::FS_EXT_PAGE : mmu_pkg::FS_EXT_SEC};
				far_reg  <= hold_va_reg;
			end
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	chk_l1_invalid_fault: assert property (
		acc && use_xlat && !hit && !walk.abort_l1 && walk.l1[1:0] == mmu_pkg::L1_FAULT
		|=> rsp.abort && rsp.status == mmu_pkg::FS_TRANS_SEC && !rsp.bus_start)
		else $error("Invalid level one descriptor did not fault.");
	chk_domain_noaccess: assert property (
		acc && use_xlat && walk_ok && !dval[0]
		|=> rsp.abort && rsp.status[3:2] == 2'h2 && rsp.status[0])
		else $error("No access domain did not raise a domain fault.");
	chk_manager_bypass: assert property (
		acc && use_xlat && (hit || walk_ok) && dval == 2'h3 |=> !rsp.abort && rsp.bus_start)
		else $error("Manager domain access was refused.");
	chk_one_fault_nobus: assert property (
		rsp.valid && rsp.abort |-> !rsp.bus_start && state_reg == mmu_pkg::ST_IDLE)
		else $error("Faulted access started a bus transfer.");
	chk_swap_write_issue: assert property (
		state_reg == mmu_pkg::ST_SWAP_RD && bus_done
		|=> swap_write_go && state_reg == mmu_pkg::ST_SWAP_WR)
		else $error("Swap write phase not issued after read phase.");
	chk_swap_unbuffered: assert property (
		rsp.bus_start && state_reg == mmu_pkg::ST_SWAP_RD |-> !rsp.bus_buffered)
		else $error("Swap went out as a buffered write.");
	chk_fsr_record: assert property (
		rsp.valid && rsp.abort && !rsp.is_instr |=> dfsr_reg == {$past(rsp.domain), $past(rsp.status)})
		else $error("Data fault status not recorded.");
	chk_ext_abort_gate: assert property (
		core_ext_abort |-> $past(ext_ok_reg) && $past(bus_err) && $past(bus_done))
		else $error("External abort passed on an ineligible access.");
endmodule
`default_nettype wire

// ==== dv/bus_memory_model.sv ====
// Purpose: System bus memory seen from the fault checker.
// Assumes: One phase is opened per start pulse.
// Notes:   Wait length and error answer are set by the bench.
`timescale 1ns/1ns
`default_nettype none
module bus_memory_model (
	input  wire logic       clk_sys,  // System clock.
	input  wire logic       nrst,     // Reset, active low.
	input  wire logic       start,    // Phase opened by the block.
	input  wire logic [3:0] delay,    // Extra wait cycles.
	input  wire logic       err_cfg,  // Answer with an error.
	output logic            bus_done, // Phase complete pulse.
	output logic            bus_err   // Error with completion.
);
	logic [4:0] cnt_reg;
	// Counts the wait and answers once per phase; error only when commanded.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_reg <= 5'h00;
			bus_done <= 1'b0;
			bus_err <= 1'b0;
		end else begin
			if (start) begin
				cnt_reg <= {1'b0, delay} + 5'h01;
			end else if (cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'h01;
			end
			bus_done <= (cnt_reg == 5'h01);
			bus_err <= err_cfg & (cnt_reg == 5'h01);
		end
	end
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// Purpose: Self-checking bench for the translation fault checker.
// Assumes: Zero-wait APB slave and one registered check result.
// Notes:   Every access starts by invalidating the unlocked translation cache entries; locked entries stay.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic              clk_sys, nrst, psel, penable, pwrite, req_valid, err_cfg;
	logic              pready, pslverr, req_ready, bus_done, bus_err, sl, ab, sw;
	logic              swap_write_go, core_ext_abort, xlat_on;
	logic [31:0]       paddr, pwdata, prdata, rd;
	logic [3:0]        delay;
	mmu_pkg::acc_req_t req;
	mmu_pkg::walk_t    walk;
	mmu_pkg::rsp_t     rsp, got;
	int                errors, num_checks, cyc;
	mmu_fault_check dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req_valid(req_valid), .req(req), .walk(walk), .req_ready(req_ready), .rsp(rsp),
		.bus_done(bus_done), .bus_err(bus_err), .swap_write_go(swap_write_go),
		.core_ext_abort(core_ext_abort), .xlat_on(xlat_on));
	bus_memory_model mem_u (.clk_sys(clk_sys), .nrst(nrst), .start((rsp.valid & rsp.bus_start) | swap_write_go),
		.delay(delay), .err_cfg(err_cfg), .bus_done(bus_done), .bus_err(bus_err));
	// Clock generation and hang guard.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One APB transfer; holds the request until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {24'h000000, a};
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic mmu_pkg::acc_req_t rq(input logic [31:0] va, input logic [5:0] f);
		rq = {va, f};
	endfunction
	function automatic logic [31:0] sect(input logic [3:0] d, input logic [1:0] p);
		sect = (32'(p) << mmu_pkg::L1_PERM_LSB) | (32'(d) << mmu_pkg::L1_DOM_LSB) | 32'(mmu_pkg::L1_SECTION);
	endfunction
	// Core access; waits out any bus transfer and gathers abort and swap pulses.
	task automatic access(input mmu_pkg::acc_req_t r, input logic [31:0] l1, input logic [31:0] l2);
		apb(1'b1, mmu_pkg::OFS_INV_ALL, 32'h00000000);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= r;
		walk <= {l1, l2, 2'b00};
		do begin
			@(posedge clk_sys);
		end while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		@(posedge clk_sys);
		got = rsp;
		ab = 1'b0;
		sw = 1'b0;
		chk("rsp valid", got.valid, 1);
		if (got.bus_start === 1'b1) begin
			do begin
				@(posedge clk_sys);
				ab |= core_ext_abort;
				sw |= swap_write_go;
			end while (req_ready !== 1'b1);
		end
	endtask
	task automatic t_trans();
		apb(1'b1, mmu_pkg::OFS_DOMAIN, 32'h00000000);
		apb(1'b1, mmu_pkg::OFS_CTRL, 32'h00000001);
		access(rq(32'h00001234, 6'h00), 32'h00000000, 32'h00000000);
		chk("trans abort", got.abort, 1);
		chk("trans status", got.status, mmu_pkg::FS_TRANS_SEC);
		chk("trans no bus", got.bus_start, 0);
		apb(1'b0, mmu_pkg::OFS_DFSR, 32'h00000000);
		chk("dfsr", rd[7:0], {4'h0, mmu_pkg::FS_TRANS_SEC});
		apb(1'b0, mmu_pkg::OFS_FADDR, 32'h00000000);
		chk("far", rd, 32'h00001234);
	endtask
	task automatic t_domain();
		logic [1:0] pm[3] = '{mmu_pkg::PERM_PRIV, mmu_pkg::PERM_PRIV, mmu_pkg::PERM_UREAD};
		logic [5:0] fl[3] = '{6'h08, 6'h00, 6'h10};
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, mmu_pkg::OFS_DOMAIN, 32'(d) << 6);
			access(rq(32'h00100000, 6'h00), sect(4'h3, mmu_pkg::PERM_NONE), 32'h00000000);
			chk("dom abort", got.abort, d != 3);
			chk("dom status", got.status, (d == 3) ? 4'h0 : (d == 1) ? mmu_pkg::FS_PERM_SEC : mmu_pkg::FS_DOM_SEC);
			chk("dom field", got.domain, 4'h3);
		end
		apb(1'b1, mmu_pkg::OFS_DOMAIN, 32'h00000040);
		for (int k = 0; k < 3; k++) begin
			access(rq(32'h00100000, fl[k]), sect(4'h3, pm[k]), 32'h00000000);
			chk("sect perm", got.abort, k != 0);
		end
	endtask
	task automatic t_quarter();
		logic [31:0] l2;
		for (int t = 0; t < 2; t++) begin
			for (int q = 0; q < 4; q++) begin
				l2 = 32'h00000CC0 | 32'((t == 1) ? mmu_pkg::L2_LARGE : mmu_pkg::L2_SMALL);
				access(rq((t == 1) ? 32'(q) << 14 : 32'(q) << 10, 6'h00), 32'h00000061, l2);
				chk("quarter abort", got.abort, q % 2 == 0);
				if (q % 2 == 0) chk("page status", got.status, mmu_pkg::FS_PERM_PAGE);
			end
		end
		access(rq(32'h00000400, 6'h00), 32'h00000061, 32'h00000003);
		chk("tiny status", got.status, mmu_pkg::FS_PERM_PAGE);
		access(rq(32'h00000400, 6'h00), 32'h00000C61, 32'h00000003);
		chk("tiny allowed", got.abort, 0);
		access(rq(32'h00000400, 6'h00), 32'h00000061, 32'h00000000);
		chk("page trans", got.status, mmu_pkg::FS_TRANS_PAGE);
	endtask
	task automatic t_lock();
		apb(1'b1, mmu_pkg::OFS_LOCK, 32'h00000001);
		access(rq(32'h00400000, 6'h08), sect(4'h3, 2'h3), 32'h00000000);
		chk("lock fill", got.tlb_hit, 0);
		apb(1'b1, mmu_pkg::OFS_LOCK, 32'h00000000);
		access(rq(32'h00400010, 6'h08), 32'h00000000, 32'h00000000);
		chk("lock hit", got.tlb_hit, 1);
		chk("lock kept", got.abort, 0);
		apb(1'b1, mmu_pkg::OFS_INV_VA, 32'h00400000);
		access(rq(32'h00400010, 6'h08), 32'h00000000, 32'h00000000);
		chk("lock gone", got.status, mmu_pkg::FS_TRANS_SEC);
	endtask
	task automatic t_flat();
		apb(1'b1, mmu_pkg::OFS_DOMAIN, 32'h00000000);
		apb(1'b1, mmu_pkg::OFS_CTRL, 32'h00000000);
		@(posedge clk_sys);
		chk("xlat off", xlat_on, 0);
		for (int i = 0; i < 3; i++) begin
			access(rq(32'h00200000, 6'h20), sect(4'h0, 2'h3), 32'h00000000);
			chk("flat fetch", got.abort, i < 2);
		end
		apb(1'b0, mmu_pkg::OFS_IFSR, 32'h00000000);
		chk("ifsr", rd[7:0], {4'h0, mmu_pkg::FS_DOM_SEC});
	endtask
	task automatic t_ext();
		logic [5:0] fl[4] = '{6'h02, 6'h13, 6'h00, 6'h12};
		err_cfg <= 1'b1;
		for (int dl = 0; dl < 6; dl += 5) begin
			delay <= 4'(dl);
			for (int k = 0; k < 4; k++) begin
				access(rq(32'h00300000, fl[k]), 32'h00000000, 32'h00000000);
				chk("ext abort", ab, k % 2 == 0 ? k == 0 : k == 3);
			end
			access(rq(32'h00300000, 6'h07), 32'h00000000, 32'h00000000);
			chk("swap unbuffered", got.bus_buffered, 0);
			chk("swap write", sw, 1);
			chk("swap abort", ab, 1);
		end
		apb(1'b0, 8'h20, 32'h00000000);
		chk("unmapped", sl, 1);
	endtask
	initial begin
		{nrst, psel, penable, pwrite, req_valid, err_cfg} = 6'h00;
		{paddr, pwdata, req, walk, delay, errors, num_checks, cyc} = '0;
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		t_trans();
		t_domain();
		t_quarter();
		t_lock();
		t_flat();
		t_ext();
		complete_run();
	end
endmodule
`default_nettype wire
